// file: shared/cspwc_regs.svh
// register offsets, field positions, codes and reset values of the sleep/pause control
`ifndef CSPWC_REGS_SVH
`define CSPWC_REGS_SVH

// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define CSPWC_CTRL_OFS       4'h0
`define CSPWC_STAT_OFS       4'h4
`define CSPWC_ADR_W          4

// control register fields
`define CSPWC_CTRL_WAKE_BIT  0
`define CSPWC_CTRL_CONT_BIT  1
`define CSPWC_CTRL_RST       2'h0

// status register fields
`define CSPWC_STAT_STATE_LSB 0
`define CSPWC_STAT_SLEEP_BIT 3
`define CSPWC_STAT_HIB_BIT   4
`define CSPWC_STAT_SUSP_BIT  5
`define CSPWC_STAT_ACK_BIT   6
`define CSPWC_STAT_DBGH_BIT  7
`define CSPWC_STAT_MODE_LSB  8
`define CSPWC_STAT_FRST_BIT  10

// ****************************************************************
// barrier immediates and reset-entry codes
// ****************************************************************
`define CSPWC_IMM_SLEEP      5'h10
`define CSPWC_IMM_HIBERNATE  5'h08
`define CSPWC_IMM_SUSPEND    5'h18
`define CSPWC_ENTRY_NORMAL   2'h0
`define CSPWC_ENTRY_SLEEP    2'h1
`define CSPWC_ENTRY_DEBUG    2'h2
`define CSPWC_ENTRY_RSVD     2'h3

// ****************************************************************
// parameter defaults
// ****************************************************************
`define CSPWC_SYNC_STAGES    2
`define CSPWC_VECTOR_BASE    32'h0000_0000
`define CSPWC_NONSEC_RST     4'h0

`endif

// file: shared/cspwc_pkg.sv
// types of the sleep/pause/wake control
package cspwc_pkg;

	// gray codes along run -> drain -> sleep and run -> pause -> ack
	typedef enum logic [2:0] {
		CSPWC_RUN    = 3'h0,
		CSPWC_SDRAIN = 3'h1,
		CSPWC_SLEEP  = 3'h3,
		CSPWC_PDRAIN = 3'h4,
		CSPWC_PHALT  = 3'h5,
		CSPWC_DHALT  = 3'h6,
		CSPWC_BOOT   = 3'h7
	} cspwc_state_type;

	typedef enum logic [1:0] {
		CSPWC_VAR_NONE = 2'h0,
		CSPWC_VAR_SLP  = 2'h1,
		CSPWC_VAR_HIB  = 2'h2,
		CSPWC_VAR_SUSP = 2'h3
	} cspwc_var_type;

endpackage

// file: logic/cspwc_sync.sv
// synchroniser: a chain of flops, the output follows once the last two agree
`timescale 1ns/10ps
`include "cspwc_regs.svh"
module cspwc_sync #(
	parameter int   STAGES  = `CSPWC_SYNC_STAGES,
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic d_i,
	output logic      q_o
);

	generate
		if (STAGES == 0)
		begin : g_bypass
			assign q_o = d_i;
		end
		else
		begin : g_chain
			logic [STAGES:0] chain_ff;
			logic            q_ff;
			logic            agree;

			// with two or more stages the first flop feeds only the second; with one it also feeds the compare
			assign agree = (chain_ff[STAGES] == chain_ff[STAGES-1]);

			always_ff @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					chain_ff <= {(STAGES+1){RST_VAL}};
					q_ff     <= RST_VAL;
				end
				else
				begin
					chain_ff <= {chain_ff[STAGES-1:0], d_i};
					q_ff     <= agree ? chain_ff[STAGES] : q_ff;
				end
			end
			assign q_o = q_ff;
		end
	endgenerate

endmodule

// file: logic/cspwc_core.sv
// sleep, pause and wake control of the core, with a wishbone register port
`timescale 1ns/10ps
`include "cspwc_regs.svh"

// Function
// - barrier immediate 16 sleep, 8 hibernate, 24 suspend
// - after sleep barrier wait for idle bus, halt, raise one status
// - in sleep either wake bit wakes; outside sleep wake is ignored
// - after a sleep barrier, resume at next instruction
// - each wake bit optionally synchronised with configurable stage count
// - debug wake request timed by update strobe or core-clock bus
// - pause: finish bus accesses, halt, raise halt acknowledge
// - pause low: resume exactly where paused
// - debug resume request asks outside logic to drop pause
// - pause, acknowledge and resume request are core-clock synchronous
// - entry code 00 starts at reset vector; 11 reserved
// - entry code 01 sleeps from reset, wake starts at vector
// - entry code 10 debug halts unless no debug; continue starts vector
// - four security select bits mark each port non-secure
// - reset passes configurable synchroniser stages, zero means synchronous
// - entry code sampled during reset, applied at release
module cspwc_core
	import cspwc_pkg::*;
#(
	parameter int          SYNC_STAGES    = `CSPWC_SYNC_STAGES,
	parameter logic [1:0]  WAKE_ASYNC_SEL = 2'h3,
	parameter int          DEBUG_LEVEL    = 1,
	parameter int          DEBUG_STYLE    = 0,
	parameter logic [31:0] VECTOR_BASE    = `CSPWC_VECTOR_BASE
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [1:0]  reset_entry_select_i,
	input  wire logic        barrier_valid_i,
	input  wire logic [4:0]  barrier_imm_i,
	input  wire logic        bus_idle_i,
	input  wire logic [1:0]  wake_request_i,
	input  wire logic        pause_i,
	input  wire logic        debug_update_strobe_i,
	input  wire logic [3:0]  access_security_select_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             sleep_o,
	output logic             hibernate_o,
	output logic             suspend_o,
	output logic             halt_ack_o,
	output logic             debug_halted_o,
	output logic             debug_wake_o,
	output logic             debug_resume_o,
	output logic             pipe_halt_o,
	output logic             resume_next_o,
	output logic             resume_vector_o,
	output logic [31:0]      reset_vector_o,
	output logic [3:0]       nonsec_o
);

	// ****************************************************************
	// reset and input synchronisers
	// ****************************************************************
	logic            rst_sync;
	logic            rst_core_n;
	logic [1:0]      wake_s;
	logic            upd_s;

	cspwc_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b0)) u_rst_sync (
		.clk_i   (sys_clk_i),
		.rst_n_i (rst_n_i),
		.d_i     (1'b1),
		.q_o     (rst_sync)
	);
	// zero stages: reset is already synchronous to the clock
	assign rst_core_n = (SYNC_STAGES == 0) ? rst_n_i : rst_sync;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_wake
			if (WAKE_ASYNC_SEL[gi])
			begin : g_async
				cspwc_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b0)) u_wake_sync (
					.clk_i   (sys_clk_i),
					.rst_n_i (rst_core_n),
					.d_i     (wake_request_i[gi]),
					.q_o     (wake_s[gi])
				);
			end
			else
			begin : g_direct
				assign wake_s[gi] = wake_request_i[gi];
			end
		end
	endgenerate

	cspwc_sync #(.STAGES(`CSPWC_SYNC_STAGES), .RST_VAL(1'b0)) u_upd_sync (
		.clk_i   (sys_clk_i),
		.rst_n_i (rst_core_n),
		.d_i     (debug_update_strobe_i),
		.q_o     (upd_s)
	);

	// ****************************************************************
	// reset-entry capture
	// ****************************************************************
	// no async reset here: the strap must be sampled, not forced
	logic [1:0] entry_ff;

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_core_n)
			entry_ff <= reset_entry_select_i;
	end

	// ****************************************************************
	// register port
	// ****************************************************************
	logic [1:0]  ctrl_ff;
	logic        ack_ff;
	logic [31:0] rdat_ff;
	logic        wb_req;
	logic        hit_ctrl;
	logic        hit_stat;
	logic        wr_ctrl;
	logic [1:0]  nxt_ctrl;
	logic [31:0] stat_word;
	logic [31:0] nxt_rdat;

	assign wb_req   = wb_cyc_i && wb_stb_i && !ack_ff;
	assign hit_ctrl = (wb_adr_i == `CSPWC_CTRL_OFS);
	assign hit_stat = (wb_adr_i == `CSPWC_STAT_OFS);
	assign wr_ctrl  = wb_req && wb_we_i && hit_ctrl && wb_sel_i[0];
	assign nxt_ctrl = wr_ctrl ? wb_dat_i[1:0] : ctrl_ff;
	// unmapped addresses answer with zero data and ignore writes
	assign nxt_rdat = !wb_req ? rdat_ff :
		hit_ctrl ? {30'h0, ctrl_ff} :
		hit_stat ? stat_word : 32'h0;

	always_ff @(posedge sys_clk_i or negedge rst_core_n)
	begin
		if (!rst_core_n)
		begin
			ctrl_ff <= `CSPWC_CTRL_RST;
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0;
		end
		else
		begin
			ctrl_ff <= nxt_ctrl;
			ack_ff  <= wb_req;
			rdat_ff <= nxt_rdat;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// ****************************************************************
	// debugger requests
	// ****************************************************************
	cspwc_state_type state_ff;
	cspwc_state_type nxt_state;
	logic upd_q_ff;
	logic dbg_tick;
	logic dwake_ff;
	logic dcont_ff;
	logic nxt_dwake;
	logic nxt_dcont;

	// style 0 follows the update strobe, style 1 the core-clock bus
	assign dbg_tick  = (DEBUG_STYLE == 1) || (upd_s && !upd_q_ff);
	assign nxt_dwake = (state_ff != CSPWC_SLEEP) ? 1'b0 :
		dbg_tick ? ctrl_ff[`CSPWC_CTRL_WAKE_BIT] : dwake_ff;
	assign nxt_dcont = !(state_ff inside {CSPWC_PHALT, CSPWC_DHALT}) ? 1'b0 :
		dbg_tick ? ctrl_ff[`CSPWC_CTRL_CONT_BIT] : dcont_ff;

	always_ff @(posedge sys_clk_i or negedge rst_core_n)
	begin
		if (!rst_core_n)
		begin
			upd_q_ff <= 1'b0;
			dwake_ff <= 1'b0;
			dcont_ff <= 1'b0;
		end
		else
		begin
			upd_q_ff <= upd_s;
			dwake_ff <= nxt_dwake;
			dcont_ff <= nxt_dcont;
		end
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	cspwc_var_type var_ff;
	cspwc_var_type nxt_var;
	cspwc_var_type bar_var;
	logic frst_ff;
	logic nxt_frst;
	logic nxt_rnext;
	logic nxt_rvec;
	logic any_wake;

	function automatic cspwc_var_type imm_decode(input logic [4:0] imm);
		unique case (imm)
			`CSPWC_IMM_SLEEP:     imm_decode = CSPWC_VAR_SLP;
			`CSPWC_IMM_HIBERNATE: imm_decode = CSPWC_VAR_HIB;
			`CSPWC_IMM_SUSPEND:   imm_decode = CSPWC_VAR_SUSP;
			default:              imm_decode = CSPWC_VAR_NONE;
		endcase
	endfunction

	assign bar_var  = imm_decode(barrier_imm_i);
	assign any_wake = |wake_s;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_var   = var_ff;
		nxt_frst  = frst_ff;
		nxt_rnext = 1'b0;
		nxt_rvec  = 1'b0;
		unique case (state_ff)
			CSPWC_BOOT:
			begin
				// reserved code 11 starts like 00
				nxt_frst = 1'b1;
				if (entry_ff == `CSPWC_ENTRY_SLEEP)
				begin
					nxt_state = CSPWC_SLEEP;
					nxt_var   = CSPWC_VAR_SLP;
				end
				else if (entry_ff == `CSPWC_ENTRY_DEBUG && DEBUG_LEVEL != 0)
					nxt_state = CSPWC_DHALT;
				else
				begin
					nxt_state = CSPWC_RUN;
					nxt_rvec  = 1'b1;
				end
			end
			CSPWC_RUN:
			begin
				nxt_frst = 1'b0;
				// a sleep barrier wins over a pause raised in the same cycle
				if (barrier_valid_i && bar_var != CSPWC_VAR_NONE)
				begin
					nxt_state = CSPWC_SDRAIN;
					nxt_var   = bar_var;
				end
				else if (pause_i)
					nxt_state = CSPWC_PDRAIN;
			end
			CSPWC_SDRAIN:
			begin
				if (bus_idle_i)
					nxt_state = CSPWC_SLEEP;
			end
			CSPWC_SLEEP:
			begin
				if (any_wake)
				begin
					nxt_state = CSPWC_RUN;
					nxt_var   = CSPWC_VAR_NONE;
					nxt_rnext = !frst_ff;
					nxt_rvec  = frst_ff;
				end
			end
			CSPWC_PDRAIN:
			begin
				// pause withdrawn before halting: nothing was stopped
				if (!pause_i)
					nxt_state = CSPWC_RUN;
				else if (bus_idle_i)
					nxt_state = CSPWC_PHALT;
			end
			CSPWC_PHALT:
			begin
				if (!pause_i)
				begin
					nxt_state = CSPWC_RUN;
					nxt_rnext = 1'b1;
				end
			end
			CSPWC_DHALT:
			begin
				if (dcont_ff)
				begin
					nxt_state = CSPWC_RUN;
					nxt_rvec  = 1'b1;
				end
			end
			default:
			begin
				nxt_state = CSPWC_BOOT;
				nxt_var   = CSPWC_VAR_NONE;
			end
		endcase
	end

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	logic       slp_ff;
	logic       hib_ff;
	logic       susp_ff;
	logic       ack_p_ff;
	logic       dhalt_ff;
	logic       phalt_ff;
	logic       rnext_ff;
	logic       rvec_ff;
	logic       dres_ff;
	logic [3:0] nsec_ff;
	logic       nxt_sleeping;

	assign nxt_sleeping = (nxt_state == CSPWC_SLEEP);

	always_ff @(posedge sys_clk_i or negedge rst_core_n)
	begin
		if (!rst_core_n)
		begin
			state_ff <= CSPWC_BOOT;
			var_ff   <= CSPWC_VAR_NONE;
			frst_ff  <= 1'b0;
			slp_ff   <= 1'b0;
			hib_ff   <= 1'b0;
			susp_ff  <= 1'b0;
			ack_p_ff <= 1'b0;
			dhalt_ff <= 1'b0;
			phalt_ff <= 1'b1;
			rnext_ff <= 1'b0;
			rvec_ff  <= 1'b0;
			dres_ff  <= 1'b0;
			nsec_ff  <= `CSPWC_NONSEC_RST;
		end
		else
		begin
			state_ff <= nxt_state;
			var_ff   <= nxt_var;
			frst_ff  <= nxt_frst;
			slp_ff   <= nxt_sleeping && nxt_var == CSPWC_VAR_SLP;
			hib_ff   <= nxt_sleeping && nxt_var == CSPWC_VAR_HIB;
			susp_ff  <= nxt_sleeping && nxt_var == CSPWC_VAR_SUSP;
			ack_p_ff <= (nxt_state == CSPWC_PHALT);
			dhalt_ff <= (nxt_state == CSPWC_DHALT);
			phalt_ff <= nxt_state inside {CSPWC_SLEEP, CSPWC_PHALT, CSPWC_DHALT, CSPWC_BOOT};
			rnext_ff <= nxt_rnext;
			rvec_ff  <= nxt_rvec;
			// same as request and acknowledge flops ANDed, but from one flop
			dres_ff  <= nxt_dcont && (nxt_state == CSPWC_PHALT);
			nsec_ff  <= access_security_select_i;
		end
	end

	// status shows the live state; the wake request waits on outside logic
	assign stat_word = {21'h0, frst_ff, entry_ff, dhalt_ff, ack_p_ff,
		susp_ff, hib_ff, slp_ff, state_ff};

	assign sleep_o         = slp_ff;
	assign hibernate_o     = hib_ff;
	assign suspend_o       = susp_ff;
	assign halt_ack_o      = ack_p_ff;
	assign debug_halted_o  = dhalt_ff;
	assign debug_wake_o    = dwake_ff;
	assign debug_resume_o  = dres_ff;
	assign pipe_halt_o     = phalt_ff;
	assign resume_next_o   = rnext_ff;
	assign resume_vector_o = rvec_ff;
	assign reset_vector_o  = VECTOR_BASE;
	assign nonsec_o        = nsec_ff;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_core_n);

	a_barrier_decode: assert property (
		state_ff == CSPWC_RUN && barrier_valid_i && barrier_imm_i == `CSPWC_IMM_HIBERNATE
		|=> var_ff == CSPWC_VAR_HIB)
		else $error("hibernate barrier not decoded");
	a_status_onehot: assert property ($onehot0({sleep_o, hibernate_o, suspend_o}))
		else $error("more than one sleep status set");
	a_sleep_after_idle: assert property (
		$rose(sleep_o | hibernate_o | suspend_o) && !frst_ff |-> $past(bus_idle_i))
		else $error("sleep status raised with bus busy");
	a_wake_exit: assert property (
		state_ff == CSPWC_SLEEP && any_wake
		|=> !sleep_o && !hibernate_o && !suspend_o)
		else $error("wake did not end sleep");
	a_resume_next: assert property (
		state_ff == CSPWC_SLEEP && any_wake && !frst_ff |=> resume_next_o && !resume_vector_o)
		else $error("sleep exit did not resume at next instruction");
	a_pause_ack: assert property (
		state_ff == CSPWC_PDRAIN && pause_i && bus_idle_i |=> halt_ack_o && pipe_halt_o)
		else $error("pause acknowledge missing");
	a_pause_release: assert property (
		halt_ack_o && !pause_i |=> !halt_ack_o ##0 resume_next_o ##1 !resume_next_o)
		else $error("pause release did not resume once");
	a_resume_req: assert property (debug_resume_o |-> halt_ack_o)
		else $error("resume request outside pause");
	a_entry_sleep: assert property (
		state_ff == CSPWC_BOOT && entry_ff == `CSPWC_ENTRY_SLEEP |=> sleep_o && pipe_halt_o)
		else $error("sleep entry from reset missing");
	a_nonsec_follow: assert property ($past(rst_core_n) |-> nonsec_o == $past(access_security_select_i))
		else $error("security select not followed");
	a_ack_hold: assert property (halt_ack_o && pause_i |=> halt_ack_o)
		else $error("acknowledge dropped while paused");

	c_sleep_cycle: cover property (sleep_o ##[1:20] resume_next_o);
	c_pause_cycle: cover property ($rose(halt_ack_o) ##[1:20] $fell(halt_ack_o));
	c_debug_exit:  cover property (debug_halted_o ##[1:50] resume_vector_o);

endmodule

// file: tb/cspwc_partner.sv
// model of the outside clock, power and reset logic that faces the core control
`timescale 1ns/10ps
module cspwc_partner (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       pause_req_i,
	input  wire logic [1:0] wake_req_i,
	input  wire logic       slow_i,
	input  wire logic       debug_wake_i,
	input  wire logic       debug_resume_i,
	input  wire logic       halt_ack_i,
	output logic            pause_o,
	output logic [1:0]      wake_o
);
	// ************
	// debug answers
	// ************
	logic [2:0] dly_ff;
	logic       dwake_ff;
	logic       cont_ff;
	logic       pause_ff;
	wire logic  dbg_req   = debug_wake_i | debug_resume_i;
	wire logic  dly_done  = (dly_ff == (slow_i ? 3'h6 : 3'h1));
	wire logic  nxt_pause = pause_req_i & ~cont_ff;

	// the delay stands for restarting a stopped clock before answering
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			dly_ff   <= 3'h0;
			dwake_ff <= 1'b0;
			cont_ff  <= 1'b0;
			pause_ff <= 1'b0;
		end
		else
		begin
			dly_ff   <= dbg_req ? dly_ff + {2'h0, ~dly_done} : 3'h0;
			dwake_ff <= debug_wake_i & (dwake_ff | dly_done);
			cont_ff  <= pause_req_i & (cont_ff | (debug_resume_i & dly_done));
			// pause moves only once the acknowledge has followed it
			if (halt_ack_i == pause_ff)
				pause_ff <= nxt_pause;
		end
	end

	assign pause_o = pause_ff;
	assign wake_o  = wake_req_i | {dwake_ff, 1'b0};
endmodule

// file: tb/cspwc_core_tb_top.sv
// self-checking bench of the sleep, pause and wake control
`timescale 1ns/10ps
`include "cspwc_regs.svh"
module cspwc_core_tb_top;
	localparam int SYNC = 2;
	localparam int K_HACK = 3, K_DHALT = 4, K_RNEXT = 5, K_RVEC = 6, K_DWAKE = 7, K_DRES = 8;
	logic        sys_clk, rst_n, barrier_valid, bus_idle, pause_req, slow, strobe, pause;
	logic [1:0]  entry, wake_req, wake;
	logic [4:0]  imm;
	logic [3:0]  nsec_sel, wb_adr, wb_sel, nsec;
	logic        wb_cyc, wb_stb, wb_we, wb_ack;
	logic [31:0] wb_wdat, wb_rdat, rvector, rd;
	logic        sleep, hib, susp, hack, dhalt, dwake, dres, phalt, rnext, rvec;
	int          mismatches, checks, seed;
	wire logic [8:0] obs = {dres, dwake, rvec, rnext, dhalt, hack, susp, hib, sleep};

	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	cspwc_core #(.SYNC_STAGES(SYNC)) dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
		.reset_entry_select_i(entry), .barrier_valid_i(barrier_valid), .barrier_imm_i(imm),
		.bus_idle_i(bus_idle), .wake_request_i(wake), .pause_i(pause),
		.debug_update_strobe_i(strobe), .access_security_select_i(nsec_sel),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.sleep_o(sleep), .hibernate_o(hib), .suspend_o(susp), .halt_ack_o(hack),
		.debug_halted_o(dhalt), .debug_wake_o(dwake), .debug_resume_o(dres),
		.pipe_halt_o(phalt), .resume_next_o(rnext), .resume_vector_o(rvec),
		.reset_vector_o(rvector), .nonsec_o(nsec));

	cspwc_partner far (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .pause_req_i(pause_req),
		.wake_req_i(wake_req), .slow_i(slow), .debug_wake_i(dwake), .debug_resume_i(dres),
		.halt_ack_i(hack), .pause_o(pause), .wake_o(wake));

	// ************
	// helpers
	// ************
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string msg);
		chk(32'(got), 32'(exp), msg);
	endtask

	function automatic logic [2:0] exp_status(input logic [4:0] im);
		case (im)
			`CSPWC_IMM_SLEEP:     exp_status = 3'h1;
			`CSPWC_IMM_HIBERNATE: exp_status = 3'h2;
			`CSPWC_IMM_SUSPEND:   exp_status = 3'h4;
			default:              exp_status = 3'h0;
		endcase
	endfunction

	// the three sleep variants and one ignored code first, then random ones
	function automatic logic [4:0] pick_imm(input int i);
		case (i)
			0:       pick_imm = `CSPWC_IMM_SLEEP;
			1:       pick_imm = `CSPWC_IMM_HIBERNATE;
			2:       pick_imm = `CSPWC_IMM_SUSPEND;
			3:       pick_imm = 5'h04;
			default: pick_imm = 5'($random(seed));
		endcase
	endfunction

	task automatic wait_for(input int k, input int lim, output int cnt);
		cnt = 0;
		while (obs[k] !== 1'b1 && cnt < lim)
		begin
			@(posedge sys_clk);
			cnt++;
		end
		chk1(obs[k], 1'b1, "wait timed out");
	endtask

	task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat,
		output logic [31:0] rdat);
		int t;
		t = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= 4'hf;
		wb_wdat <= dat;
		do
		begin
			@(posedge sys_clk);
			t++;
		end
		while (wb_ack !== 1'b1 && t < 20);
		chk1(wb_ack, 1'b1, "no bus ack");
		rdat = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge sys_clk);
	endtask

	// strobe stays up between calls so each call gives exactly one rising edge
	task automatic dbg_ctrl(input logic [1:0] bits);
		strobe <= 1'b0;
		repeat (4) @(posedge sys_clk);
		wb_xfer(1'b1, `CSPWC_CTRL_OFS, {30'h0, bits}, rd);
		strobe <= 1'b1;
	endtask

	// ************
	// scenarios
	// ************
	task automatic entry_test(input logic [1:0] code);
		int cnt;
		rst_n <= 1'b0;
		entry <= code;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		if (code == `CSPWC_ENTRY_SLEEP)
		begin
			wait_for(0, 20, cnt);
			chk1(rvec, 1'b0, "vector start while asleep");
			wake_req <= 2'h1;
			wait_for(K_RVEC, 30, cnt);
			wake_req <= 2'h0;
		end
		else if (code == `CSPWC_ENTRY_DEBUG)
		begin
			wait_for(K_DHALT, 20, cnt);
			dbg_ctrl(2'h2);
			wait_for(K_RVEC, 30, cnt);
			dbg_ctrl(2'h0);
		end
		else
		begin
			wait_for(K_RVEC, 20, cnt);
			chk(32'(cnt >= SYNC), 32'h1, "start before reset sync");
		end
		chk(rvector, `CSPWC_VECTOR_BASE, "reset vector");
		repeat (8) @(posedge sys_clk);
	endtask

	task automatic sleep_cycle(input logic [4:0] im, input logic viadbg);
		logic [2:0] e;
		int         busy;
		int         cnt;
		e = exp_status(im);
		busy = 1 + ($unsigned($random(seed)) % 4);
		bus_idle <= 1'b0;
		barrier_valid <= 1'b1;
		imm <= im;
		@(posedge sys_clk);
		barrier_valid <= 1'b0;
		imm <= 5'($random(seed));
		repeat (busy)
		begin
			@(posedge sys_clk);
			chk(32'(obs[2:0]), 32'h0, "status while bus busy");
		end
		bus_idle <= 1'b1;
		if (e == 3'h0)
		begin
			repeat (5)
			begin
				@(posedge sys_clk);
				chk(32'({obs[2:0], phalt}), 32'h0, "other immediate acted");
			end
			return;
		end
		wait_for(e[0] ? 0 : (e[1] ? 1 : 2), 20, cnt);
		chk(32'(obs[2:0]), 32'(e), "status kind");
		chk1(phalt, 1'b1, "pipe not halted");
		wb_xfer(1'b0, `CSPWC_STAT_OFS, 32'h0, rd);
		chk(32'(rd[`CSPWC_STAT_SUSP_BIT:`CSPWC_STAT_SLEEP_BIT]), 32'(e), "status read");
		if (viadbg)
		begin
			dbg_ctrl(2'h1);
			wait_for(K_DWAKE, 20, cnt);
		end
		else
			wake_req <= 2'h1 << ($unsigned($random(seed)) % 2);
		wait_for(K_RNEXT, 40, cnt);
		chk(32'(obs[2:0]), 32'h0, "status after wake");
		@(posedge sys_clk);
		chk1(rnext, 1'b0, "resume pulse too long");
		wake_req <= 2'h0;
		if (viadbg)
			dbg_ctrl(2'h0);
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic pause_cycle(input logic viadbg);
		int busy;
		int cnt;
		busy = 2 + ($unsigned($random(seed)) % 4);
		bus_idle <= 1'b0;
		pause_req <= 1'b1;
		repeat (busy)
		begin
			@(posedge sys_clk);
			chk1(hack, 1'b0, "ack while bus busy");
		end
		bus_idle <= 1'b1;
		wait_for(K_HACK, 20, cnt);
		chk1(phalt, 1'b1, "pipe not halted");
		wb_xfer(1'b0, `CSPWC_STAT_OFS, 32'h0, rd);
		chk1(rd[`CSPWC_STAT_ACK_BIT], 1'b1, "ack read");
		if (viadbg)
		begin
			dbg_ctrl(2'h2);
			wait_for(K_DRES, 20, cnt);
		end
		else
			pause_req <= 1'b0;
		wait_for(K_RNEXT, 40, cnt);
		chk1(hack, 1'b0, "ack after release");
		@(posedge sys_clk);
		chk1(rnext, 1'b0, "resume pulse too long");
		pause_req <= 1'b0;
		if (viadbg)
			dbg_ctrl(2'h0);
		repeat (4) @(posedge sys_clk);
	endtask

	// ************
	// main sequence
	// ************
	initial
	begin
		seed = 52895;
		mismatches = 0;
		checks = 0;
		{rst_n, entry, barrier_valid, imm, pause_req, wake_req, slow, strobe} = '0;
		{nsec_sel, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
		bus_idle = 1'b1;
		@(posedge sys_clk);
		for (int c = 0; c < 4; c++)
			entry_test(2'(c));
		wake_req <= 2'h3;
		repeat (10)
		begin
			@(posedge sys_clk);
			chk1(rnext | sleep, 1'b0, "wake acted while running");
		end
		wake_req <= 2'h0;
		repeat (6) @(posedge sys_clk);
		for (int i = 0; i < 7; i++)
			sleep_cycle(pick_imm(i), 1'b0);
		slow <= 1'b1;
		sleep_cycle(`CSPWC_IMM_SLEEP, 1'b1);
		pause_cycle(1'b1);
		slow <= 1'b0;
		pause_cycle(1'b0);
		pause_cycle(1'b0);
		repeat (8)
		begin
			nsec_sel <= 4'($random(seed));
			repeat (2) @(posedge sys_clk);
			chk(32'(nsec), 32'(nsec_sel), "security select");
		end
		wb_xfer(1'b1, 4'h8, $random(seed), rd);
		wb_xfer(1'b0, 4'h8, 32'h0, rd);
		chk(rd, 32'h0, "unmapped read");
		final_report;
	end

	initial
	begin
		repeat (6000) @(posedge sys_clk);
		mismatches++;
		final_report;
	end
endmodule
